//--- hardware_return_stack.sv
// Hardware return-address stack for a small microcontroller core
//
// Notes on behaviour
// - Depth is a parameter fixed by the chosen core variant.
// - Twelve-bit core holds two return addresses.
// - Fourteen-bit core holds eight return addresses.
// - Sixteen-bit core holds sixteen return addresses.
// - Enhanced sixteen-bit core holds thirty-one return addresses.
// - Twelve/fourteen-bit: call or interrupt pushes PC plus one.
// - Sixteen-bit: call, long call or interrupt pushes PC plus one.
// - Twelve-bit: only return with literal pops into the PC.
// - Wider cores: literal return, return, interrupt return all pop.
// - Push onto a full stack still stores and flags overflow.
// - Twelve/fourteen-bit: popping an empty stack flags underflow.
// - Twelve-bit empty pop returns the previously popped value.
// - Fourteen-bit empty pop wraps pointer to top of full stack.
// - Fourteen-bit: pop after wrap raises no further underflow.
// - Sixteen-bit overflow clears stack space flag until reset.
// - Overflow and underflow reported only while break enable set.
// - Enhanced core overflow stores, flags, clears space flag.
`timescale 1ns/1ps
`include "hrs_cfg.svh"
module hardware_return_stack import hrs_pkg::*; #(
    parameter hrs_core_e CORE = hrs_core_14, // Core variant
    parameter int PC_W = `HRS_PC_W // Program counter width
) (
    input wire logic mclk, // System clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [PC_W-1:0] pc, // Current program counter
    input wire logic do_call, // Call instruction strobe
    input wire logic do_long_call, // Long call instruction strobe
    input wire logic do_irq, // Interrupt taken strobe
    input wire logic do_return_with_literal, // Return with literal strobe
    input wire logic do_return, // Return strobe
    input wire logic do_return_from_interrupt, // Return from interrupt strobe
    input wire logic break_enable, // Stack overflow break enable
    output logic [PC_W-1:0] return_pc_q, // Popped return address
    output logic return_valid_q, // Return address valid, one cycle
    output logic overflow_q, // Overflow indication, one cycle
    output logic underflow_q, // Underflow indication, one cycle
    output logic stack_space_flag, // Space available, wide cores
    output logic [5:0] level_q // Entries currently held
);

    // ------------------------------------------------------------------
    // Depth selection
    // ------------------------------------------------------------------
    // Depth fixed per variant
    localparam int DEPTH = (CORE == hrs_core_12) ? `HRS_DEPTH_C12 :   // two
                           (CORE == hrs_core_14) ? `HRS_DEPTH_C14 :   // eight
                           (CORE == hrs_core_16) ? `HRS_DEPTH_C16 :   // sixteen
                           `HRS_DEPTH_C18;                            // thirty-one
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [5:0] DEPTH_L = 6'(DEPTH);
    localparam logic [PTR_W-1:0] TOP_IDX = PTR_W'(DEPTH - 1);
    localparam bit WIDE_CORE = (CORE == hrs_core_16) || (CORE == hrs_core_18);

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    logic [PC_W-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] wr_ptr_d;
    logic [PTR_W-1:0] rd_idx;
    logic [5:0] level_d;
    logic wrapped_q;
    logic [PC_W-1:0] last_pop_q;
    logic [PC_W-1:0] push_val;
    hrs_op_e op;
    logic do_push;
    logic do_pop;
    logic is_full;
    logic is_empty;
    logic ovf_evt;
    logic unf_evt;
    logic space_q;

    hrs_decode #(
        .CORE(CORE)
    ) u_decode (
        .do_call(do_call),
        .do_long_call(do_long_call),
        .do_irq(do_irq),
        .do_return_with_literal(do_return_with_literal),
        .do_return(do_return),
        .do_return_from_interrupt(do_return_from_interrupt),
        .op(op)
    );

    assign do_push = (op == hrs_op_push);
    assign do_pop = (op == hrs_op_pop);
    assign is_full = (level_q == DEPTH_L);
    assign is_empty = (level_q == 6'h00);
    // Saved value is PC plus one
    assign push_val = pc + PC_W'(`HRS_PC_INC);
    assign rd_idx = (wr_ptr_q == '0) ? TOP_IDX : wr_ptr_q - PTR_W'(1);

    // ------------------------------------------------------------------
    // Pointer arithmetic
    // ------------------------------------------------------------------
    // Circular pointer: a full stack keeps storing and overwrites the oldest
    always_comb begin
        wr_ptr_d = wr_ptr_q;
        level_d = level_q;
        if (do_push) begin
            wr_ptr_d = (wr_ptr_q == TOP_IDX) ? '0 : wr_ptr_q + PTR_W'(1);
            if (!is_full) begin
                level_d = level_q + 6'h01;
            end
        end else if (do_pop) begin
            if (!is_empty) begin
                wr_ptr_d = rd_idx;
                level_d = level_q - 6'h01;
            end else if (CORE == hrs_core_14) begin
                // Wrap to top of a full stack
                wr_ptr_d = rd_idx;
                level_d = DEPTH_L - 6'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_ptr_q <= PTR_W'(`HRS_PTR_RST);
            level_q <= 6'(`HRS_PTR_RST);
        end else begin
            wr_ptr_q <= wr_ptr_d;
            level_q <= level_d;
        end
    end

    // ------------------------------------------------------------------
    // Entry storage
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            // Push always stores, even when full
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    mem_q[gi] <= '0;
                end else if (do_push && wr_ptr_q == PTR_W'(gi)) begin
                    mem_q[gi] <= push_val;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Return address output
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            return_pc_q <= '0;
            return_valid_q <= 1'b0;
            last_pop_q <= '0;
        end else begin
            return_valid_q <= do_pop;
            if (do_pop) begin
                if (is_empty && CORE == hrs_core_12) begin
                    return_pc_q <= last_pop_q;
                end else begin
                    return_pc_q <= mem_q[rd_idx];
                    last_pop_q <= mem_q[rd_idx];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Wrap tracking and error reporting
    // ------------------------------------------------------------------
    // Remember a wrap so the next pop stays quiet
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wrapped_q <= 1'b0;
        end else if (do_push) begin
            wrapped_q <= 1'b0;
        end else if (do_pop && CORE == hrs_core_14) begin
            wrapped_q <= is_empty;
        end
    end

    // Overflow on push into a full stack
    assign ovf_evt = do_push && is_full;
    // Underflow on narrow cores only, suppressed after a wrap
    assign unf_evt = do_pop && is_empty && !WIDE_CORE && !wrapped_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            overflow_q <= 1'b0;
            underflow_q <= 1'b0;
        end else begin
            overflow_q <= ovf_evt && break_enable;
            underflow_q <= unf_evt && break_enable;
        end
    end

    // ------------------------------------------------------------------
    // Stack space flag
    // ------------------------------------------------------------------
    // Overflow drops the flag until reset; reset sets it
    hrs_flag_sticky u_space (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear_evt(ovf_evt),
        .flag_q(space_q)
    );

    // Narrow cores have no such bit; they read constant one
    assign stack_space_flag = WIDE_CORE ? space_q : `HRS_SPACE_RST;

endmodule // hardware_return_stack

//--- hardware_return_stack_tb.sv
// Bench: all four core variants side by side against one circular-storage reference model
`timescale 1ns/1ps
module hardware_return_stack_tb;
    import hrs_pkg::*;
    logic mclk, rst_n, break_enable, d_c, d_l, d_i, d_w, d_r, d_f;
    logic [2:0] cmd;
    logic [20:0] pc;
    logic [20:0] rpc [4], mem [4][32], erpc [4];
    logic rv [4], ov [4], uf [4], sf [4];
    logic [5:0] lvl [4];
    int dp [4] = '{2, 8, 16, 31};
    int wp [4], lv [4], fails, comparisons, cyc, seed;
    bit erv [4], eov [4], euf [4], esp [4];
    hrs_seq_model seq_u (.cmd(cmd), .do_call(d_c), .do_long_call(d_l), .do_irq(d_i),
        .do_return_with_literal(d_w), .do_return(d_r), .do_return_from_interrupt(d_f));
    for (genvar g = 0; g < 4; g++) begin : core_g
        hardware_return_stack #(.CORE(hrs_core_e'(g))) dut_u (.mclk(mclk), .rst_n(rst_n),
            .pc(pc), .do_call(d_c), .do_long_call(d_l), .do_irq(d_i), .do_return_with_literal(d_w),
            .do_return(d_r), .do_return_from_interrupt(d_f), .break_enable(break_enable),
            .return_pc_q(rpc[g]), .return_valid_q(rv[g]), .overflow_q(ov[g]),
            .underflow_q(uf[g]), .stack_space_flag(sf[g]), .level_q(lvl[g]));
    end
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task check;
        for (int c = 0; c < 4; c++) begin
            chk("return_valid_q", rv[c], erv[c]);
            chk("return_pc_q", rpc[c], erpc[c]);
            chk("overflow_q", ov[c], eov[c]);
            chk("underflow_q", uf[c], euf[c]);
            chk("level_q", lvl[c], lv[c]);
            chk("stack_space_flag", sf[c], esp[c]);
        end
    endtask
    // -------------------------------------------------------------
    // Reference model, circular storage with saturating level
    // -------------------------------------------------------------
    task model(input int op, input logic [20:0] r, input bit be);
        bit ps, pp;
        for (int c = 0; c < 4; c++) begin
            ps = op == 1 || op == 3 || (op == 2 && c >= 2);
            pp = !ps && (op == 4 || (op >= 5 && c >= 1));
            erv[c] = 0;
            eov[c] = 0;
            euf[c] = 0;
            if (ps) begin
                mem[c][wp[c]] = r + 21'h1;
                wp[c] = (wp[c] + 1) % dp[c];
                if (lv[c] == dp[c]) begin
                    eov[c] = be;
                    if (c >= 2) esp[c] = 0;
                end else lv[c]++;
            end else if (pp && lv[c] > 0) begin
                wp[c] = (wp[c] + dp[c] - 1) % dp[c];
                erpc[c] = mem[c][wp[c]];
                lv[c]--;
                erv[c] = 1;
            end else if (pp && c < 2) begin
                erv[c] = 1;
                euf[c] = be;
                if (c == 1) begin
                    wp[c] = (wp[c] + 7) % 8;
                    erpc[c] = mem[c][wp[c]];
                    lv[c] = 7;
                end
            end else if (pp) begin
                // Wide cores: empty pop moves nothing, returns the slot below the pointer
                erv[c] = 1;
                erpc[c] = mem[c][(wp[c] + dp[c] - 1) % dp[c]];
            end
        end
    endtask
    task step(input int op, input bit be);
        int r;
        r = $random(seed);
        @(posedge mclk);
        cmd <= op[2:0];
        pc <= r[20:0];
        break_enable <= be;
        #1;
        check();
        model(op, r[20:0], be);
    endtask
    // One test: n random commands from lo upwards, then an idle step to see the last one
    task run(input string nm, input int n, input int lo, input int span, input bit be);
        for (int i = 0; i < n; i++) step(lo + {$random(seed)} % span, be);
        step(0, be);
        $display("test %s done", nm);
    endtask
    task reset_all;
        @(posedge mclk);
        rst_n <= 0;
        cmd <= 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1;
        #1;
        for (int c = 0; c < 4; c++) begin
            wp[c] = 0;
            lv[c] = 0;
            erpc[c] = 0;
            {erv[c], eov[c], euf[c]} = 3'b000;
            esp[c] = 1;
            // Reset clears every slot, so empty pops on wide cores are predictable
            for (int i = 0; i < 32; i++) mem[c][i] = '0;
        end
        check();
    endtask
    task end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        seed = 32'h8476;
        {rst_n, break_enable, cmd, pc} = 0;
        reset_all();
        step(1, 1);
        step(4, 1);
        run("walk", 0, 0, 1, 1);
        run("fill", 34, 1, 3, 1);
        run("drain", 36, 4, 3, 1);
        run("mixed", 150, 1, 6, 1);
        run("masked_fill", 40, 1, 3, 0);
        run("masked_drain", 40, 4, 3, 0);
        reset_all();
        run("refill", 34, 1, 3, 1);
        run("mixed_again", 100, 1, 6, 1);
        end_sim();
    end
endmodule // hardware_return_stack_tb

//--- hrs_cfg.svh
// Constants for the hardware return stack
`ifndef HRS_CFG_SVH
`define HRS_CFG_SVH

// ----------------------------------------------------------------------
// Depth per core variant
// ----------------------------------------------------------------------
`define HRS_DEPTH_C12 2
`define HRS_DEPTH_C14 8
`define HRS_DEPTH_C16 16
`define HRS_DEPTH_C18 31

// ----------------------------------------------------------------------
// Widths, increments and reset values
// ----------------------------------------------------------------------
`define HRS_PC_W 21
`define HRS_PC_INC 1
`define HRS_PTR_RST 0
`define HRS_SPACE_RST 1'b1

`endif

//--- hrs_chk.sv
// Port-level checker for the hardware return stack
`timescale 1ns/1ps
module hrs_chk import hrs_pkg::*; #(
    parameter hrs_core_e CORE = hrs_core_14, // Core variant
    parameter int PC_W = 21 // PC width
) (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Reset
    input wire logic [PC_W-1:0] pc, // PC
    input wire logic do_call, // Strobe
    input wire logic do_long_call, // Strobe
    input wire logic do_irq, // Strobe
    input wire logic do_return_with_literal, // Strobe
    input wire logic do_return, // Strobe
    input wire logic do_return_from_interrupt, // Strobe
    input wire logic break_enable, // Gate
    input wire logic [PC_W-1:0] return_pc_q, // Popped
    input wire logic return_valid_q, // Pulse
    input wire logic overflow_q, // Pulse
    input wire logic underflow_q, // Pulse
    input wire logic stack_space_flag, // Sticky
    input wire logic [5:0] level_q // Count
);
    localparam bit WIDE = CORE == hrs_core_16 || CORE == hrs_core_18;
    localparam int DEPTH = CORE == hrs_core_12 ? 2 : CORE == hrs_core_14 ? 8 : WIDE ? 16 : 31;
    localparam int DEPTH_V = CORE == hrs_core_18 ? 31 : DEPTH;
    wire logic push = do_call || do_irq || (do_long_call && WIDE);
    wire logic pop_any = do_return || do_return_from_interrupt;
    wire logic pop = !push && (do_return_with_literal || (CORE != hrs_core_12 && pop_any));
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_full_overflow: assert property (push && level_q == DEPTH_V |=>
        overflow_q == $past(break_enable) && level_q == DEPTH_V) else $error("overflow wrong");
    a_pop_count: assert property (pop && level_q != 6'h00 |=>
        return_valid_q && level_q == $past(level_q) - 6'h1) else $error("pop count wrong");
    a_push_value: assert property (push ##1 pop |=>
        return_pc_q == $past(pc, 2) + PC_W'(1)) else $error("return address wrong");
    a_empty_under: assert property (pop && level_q == 6'h00 |=>
        underflow_q == (!WIDE && $past(break_enable))) else $error("underflow wrong");
    a_wrap_level: assert property (pop && level_q == 6'h00 && CORE == hrs_core_14 |=>
        level_q == 6'h7) else $error("wrap level wrong");
    a_pulse_gated: assert property (!break_enable |=> !overflow_q && !underflow_q)
        else $error("pulse while masked");
    a_space_sticky: assert property (!stack_space_flag |=> !stack_space_flag)
        else $error("space flag set again");
    a_valid_cause: assert property (return_valid_q |-> $past(pop))
        else $error("valid without pop");
    a_level_bound: assert property (level_q <= DEPTH_V) else $error("level above depth");
endmodule // hrs_chk
bind hardware_return_stack hrs_chk #(.CORE(CORE), .PC_W(PC_W)) chk_u (.mclk(mclk),
    .rst_n(rst_n), .pc(pc), .do_call(do_call), .do_long_call(do_long_call), .do_irq(do_irq),
    .do_return_with_literal(do_return_with_literal), .do_return(do_return),
    .do_return_from_interrupt(do_return_from_interrupt), .break_enable(break_enable),
    .return_pc_q(return_pc_q), .return_valid_q(return_valid_q), .overflow_q(overflow_q),
    .underflow_q(underflow_q), .stack_space_flag(stack_space_flag), .level_q(level_q));

//--- hrs_decode.sv
// Push and pop decode from sequencer strobes, per core variant
`timescale 1ns/1ps
`include "hrs_cfg.svh"
module hrs_decode import hrs_pkg::*; #(
    parameter hrs_core_e CORE = hrs_core_14
) (
    input wire logic do_call, // Call instruction executes
    input wire logic do_long_call, // Long call instruction executes
    input wire logic do_irq, // Interrupt taken
    input wire logic do_return_with_literal, // Return with literal executes
    input wire logic do_return, // Plain return executes
    input wire logic do_return_from_interrupt, // Return from interrupt executes
    output hrs_op_e op // Decoded stack operation
);
    logic push_req;
    logic pop_req;

    always_comb begin
        push_req = do_call | do_irq;
        // Long call also pushes on wide cores
        if (CORE == hrs_core_16 || CORE == hrs_core_18) begin
            push_req = push_req | do_long_call;
        end
        // Twelve-bit core pops on literal return only
        if (CORE == hrs_core_12) begin
            pop_req = do_return_with_literal;
        end else begin
            pop_req = do_return_with_literal | do_return | do_return_from_interrupt;
        end
        // Push wins if the sequencer ever strobes both
        if (push_req) begin
            op = hrs_op_push;
        end else if (pop_req) begin
            op = hrs_op_pop;
        end else begin
            op = hrs_op_none;
        end
    end
endmodule // hrs_decode

//--- hrs_flag_sticky.sv
// Sticky status bit: set by reset, cleared by an event until reset
`timescale 1ns/1ps
module hrs_flag_sticky (
    input wire logic mclk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic clear_evt, // Event that drops the bit
    output logic flag_q // Sticky flag
);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_q <= 1'b1;
        end else if (clear_evt) begin
            flag_q <= 1'b0;
        end
    end
endmodule // hrs_flag_sticky

//--- hrs_pkg.sv
// Types shared by the hardware return stack files
package hrs_pkg;

    // Core variant selection
    typedef enum logic [1:0] {
        hrs_core_12 = 2'b00,
        hrs_core_14 = 2'b01,
        hrs_core_16 = 2'b10,
        hrs_core_18 = 2'b11
    } hrs_core_e;

    // Stack operation decoded from the sequencer strobes
    typedef enum logic [1:0] {
        hrs_op_none = 2'b00,
        hrs_op_push = 2'b01,
        hrs_op_pop = 2'b10
    } hrs_op_e;

endpackage

//--- hrs_seq_model.sv
// Sequencer model: combinational instruction strobes from a bench command
`timescale 1ns/1ps
module hrs_seq_model (
    cmd, // 1 call, 2 long call, 3 irq, 4..6 returns
    do_call, // Call strobe
    do_long_call, // Long call strobe
    do_irq, // Interrupt strobe
    do_return_with_literal, // Literal return strobe
    do_return, // Return strobe
    do_return_from_interrupt // Interrupt return strobe
);
    input wire logic [2:0] cmd;
    output logic do_call;
    output logic do_long_call;
    output logic do_irq;
    output logic do_return_with_literal;
    output logic do_return;
    output logic do_return_from_interrupt;
    // Strobes decode cmd directly, so each lasts as long as the bench holds cmd
    assign do_call = cmd == 3'h1;
    assign do_long_call = cmd == 3'h2;
    assign do_irq = cmd == 3'h3;
    assign do_return_with_literal = cmd == 3'h4;
    assign do_return = cmd == 3'h5;
    assign do_return_from_interrupt = cmd == 3'h6;
endmodule // hrs_seq_model
